/* File: core/ptcs_regs.v */
`timescale 1ns/100ps
`include "ptcs_map.vh"
module ptcs_regs #(
  parameter DATA_W = 24
) (
  input wire sys_clk,
  input wire reset,
  // register port: one-cycle write or read strobe
  input wire [7:0] reg_addr,
  input wire [DATA_W-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [DATA_W-1:0] reg_rdata,
  output reg reg_rvalid,
  // lock detect threshold from the neighbouring register
  input wire [9:0] lock_thresh,
  // reference cycles counted inside the timing window
  input wire [9:0] lock_window_count,
  input wire lock_window_done,
  // register 1 bit 15 gate
  input wire slip_global_en,
  input wire phase_error_full_cycle,
  input wire [2:0] modulator_overflow_flags,
  input wire sweep_active_flag,
  // sensor sample trigger and signed temperature in degrees celsius
  input wire temp_sample_strobe,
  input wire signed [9:0] temp_celsius,
  // pad data from the output selector
  input wire [2:0] aux_pad_data,
  output wire [2:0] aux_output_pin_data,
  output wire [2:0] aux_output_pin_oe,
  output wire slip_guard_active,
  output reg slip_guard_kick,
  output reg slip_guard_retard,
  output reg [3:0] slip_guard_step,
  output wire detector_reset,
  output wire charge_pump_hiz,
  output wire temp_sensor_enable,
  output wire lock_flag
);
  // ----------------------------------------
  // writable registers, temperature code and lock state
  // ----------------------------------------
  reg [DATA_W-1:0] out_ctrl;
  reg [DATA_W-1:0] slip_ctrl;
  reg [DATA_W-1:0] temp_ctrl;
  reg [6:0] temp_code;
  reg lock_state;
  wire wr_out;
  wire wr_slip;
  wire wr_temp;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // only the three writable words get a write strobe
  function addr_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = strobe && (addr == target);
    end
  endfunction

  // read-only and reserved addresses have no write path
  assign wr_out = addr_hit(reg_write, reg_addr, `PTCS_ADDR_OUT_CTRL);
  assign wr_slip = addr_hit(reg_write, reg_addr, `PTCS_ADDR_SLIP_CTRL);
  assign wr_temp = addr_hit(reg_write, reg_addr, `PTCS_ADDR_TEMP_CTRL);

  // ----------------------------------------
  // output control word
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      out_ctrl <= `PTCS_RST_OUT_CTRL;
    end else if (wr_out) begin
      out_ctrl <= reg_wdata;
    end
  end

  // ----------------------------------------
  // slip guard control word
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      slip_ctrl <= `PTCS_RST_SLIP_CTRL;
    end else if (wr_slip) begin
      slip_ctrl <= reg_wdata;
    end
  end

  // ----------------------------------------
  // temperature sensor control word
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      temp_ctrl <= `PTCS_RST_TEMP_CTRL;
    end else if (wr_temp) begin
      temp_ctrl <= reg_wdata;
    end
  end

  // ----------------------------------------
  // output pads
  // ----------------------------------------
  wire drive_en = out_ctrl[`PTCS_OUT_EN_BIT];
  wire [2:0] pad_dis = out_ctrl[`PTCS_OUT_MASK_HI:`PTCS_OUT_MASK_LO];

  // a pad drives only with the global enable up and its own mask bit clear
  function pad_on;
    input en_in;
    input dis_in;
    begin
      pad_on = en_in && !dis_in;
    end
  endfunction

  assign aux_output_pin_oe[0] = pad_on(drive_en, pad_dis[0]);
  assign aux_output_pin_oe[1] = pad_on(drive_en, pad_dis[1]);
  assign aux_output_pin_oe[2] = pad_on(drive_en, pad_dis[2]);
  assign aux_output_pin_data = aux_pad_data;

  // ----------------------------------------
  // slip guard
  // ----------------------------------------
  wire [3:0] step = slip_ctrl[`PTCS_STEP_HI:`PTCS_STEP_LO];
  wire ovr = slip_ctrl[`PTCS_OVR_BIT];
  wire pd_rst_n = slip_ctrl[`PTCS_PDRST_BIT];
  assign slip_guard_active = (step != 4'h0) && pd_rst_n && slip_global_en;
  // override set: software bit drives reset; clear: logic leaves it released
  assign detector_reset = ovr ? ~pd_rst_n : 1'b0;
  assign charge_pump_hiz = detector_reset;

  // ----------------------------------------
  // slip guard outputs
  // ----------------------------------------
  // no kick while the detector is held in reset
  always @(posedge sys_clk) begin
    if (reset) begin
      slip_guard_kick <= 1'b0;
    end else begin
      slip_guard_kick <= slip_guard_active && phase_error_full_cycle
        && !detector_reset;
    end
  end

  // first step bit picks the direction
  always @(posedge sys_clk) begin
    if (reset) begin
      slip_guard_retard <= 1'b0;
    end else begin
      slip_guard_retard <= step[0];
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      slip_guard_step <= 4'h0;
    end else begin
      slip_guard_step <= step;
    end
  end

  // ----------------------------------------
  // temperature sensor
  // ----------------------------------------
  assign temp_sensor_enable = temp_ctrl[`PTCS_TEMP_EN_BIT];
  wire signed [10:0] t_off = {temp_celsius[9], temp_celsius} + 11'sd40;
  // (t+40)/17.5 == 2*(t+40)/35
  wire [11:0] t_dbl = {t_off[10:0], 1'b0};

  function [6:0] temp_quant;
    input signed [10:0] off;
    input [11:0] dbl;
    reg [11:0] quot;
    begin
      quot = dbl / 12'd35;
      if (off < 11'sd0) begin
        temp_quant = 7'h00;
      end else if (dbl >= 12'd245) begin
        temp_quant = 7'h07;
      end else begin
        temp_quant = quot[6:0];
      end
    end
  endfunction

  always @(posedge sys_clk) begin
    if (reset) begin
      temp_code <= `PTCS_RST_TEMP_READ;
    end else if (temp_sensor_enable && temp_sample_strobe) begin
      temp_code <= temp_quant(t_off, t_dbl);
    end
  end

  // ----------------------------------------
  // lock detect
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      lock_state <= 1'b0;
    end else if (lock_window_done) begin
      lock_state <= (lock_window_count >= lock_thresh);
    end
  end
  assign lock_flag = lock_state;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  reg [DATA_W-1:0] next_rdata;
  always @* begin
    next_rdata = {DATA_W{1'b0}};
    case (reg_addr)
      `PTCS_ADDR_OUT_CTRL: begin
        next_rdata = out_ctrl;
      end
      `PTCS_ADDR_SLIP_CTRL: begin
        next_rdata = slip_ctrl;
      end
      `PTCS_ADDR_RSVD_A: begin
        next_rdata = {DATA_W{1'b0}};
      end
      `PTCS_ADDR_TEMP_CTRL: begin
        next_rdata = temp_ctrl;
      end
      `PTCS_ADDR_STATUS: begin
        next_rdata = {{(DATA_W-6){1'b0}}, sweep_active_flag, 1'b0,
          modulator_overflow_flags, lock_state};
      end
      `PTCS_ADDR_RSVD_B: begin
        next_rdata = `PTCS_RST_RSVD_B;
      end
      `PTCS_ADDR_TEMP_READ: begin
        next_rdata = {{(DATA_W-7){1'b0}}, temp_code};
      end
      `PTCS_ADDR_RSVD_C: begin
        next_rdata = {DATA_W{1'b0}};
      end
      default: begin
        next_rdata = {DATA_W{1'b0}};
      end
    endcase
  end

  // ----------------------------------------
  // read answer
  // ----------------------------------------
  // valid pulses one cycle after each read strobe
  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
    end
  end

  // data holds until the next read
  always @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= {DATA_W{1'b0}};
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end
endmodule // ptcs_regs

/* File: pkg/ptcs_map.vh */
`ifndef PTCS_MAP_VH
`define PTCS_MAP_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define PTCS_ADDR_OUT_CTRL 8'h1b
`define PTCS_ADDR_SLIP_CTRL 8'h1c
`define PTCS_ADDR_RSVD_A 8'h1d
`define PTCS_ADDR_TEMP_CTRL 8'h1e
`define PTCS_ADDR_STATUS 8'h1f
`define PTCS_ADDR_RSVD_B 8'h20
`define PTCS_ADDR_TEMP_READ 8'h21
`define PTCS_ADDR_RSVD_C 8'h22
// ----------------------------------------
// field positions
// ----------------------------------------
`define PTCS_OUT_EN_BIT 7
`define PTCS_OUT_MASK_LO 8
`define PTCS_OUT_MASK_HI 10
`define PTCS_STEP_LO 0
`define PTCS_STEP_HI 3
`define PTCS_OVR_BIT 4
`define PTCS_PDRST_BIT 5
`define PTCS_TEMP_EN_BIT 0
// ----------------------------------------
// reset values
// ----------------------------------------
`define PTCS_RST_OUT_CTRL 24'h000000
`define PTCS_RST_SLIP_CTRL 24'h000020
`define PTCS_RST_TEMP_CTRL 24'h000000
`define PTCS_RST_RSVD_B 24'h000020
`define PTCS_RST_TEMP_READ 7'h1f
`define PTCS_RST_LOCK_THRESH 10'h040
`endif

/* File: tb/ptcs_regs_chk.sv */
`timescale 1ns/100ps
module ptcs_chk (
  input wire sys_clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire reg_read,
  input wire [23:0] reg_rdata,
  input wire [9:0] lock_thresh,
  input wire [9:0] lock_window_count,
  input wire lock_window_done,
  input wire slip_global_en,
  input wire phase_error_full_cycle,
  input wire slip_guard_active,
  input wire slip_guard_kick,
  input wire detector_reset,
  input wire charge_pump_hiz,
  input wire lock_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  rsvd_zero_a: assert property (reg_read && reg_addr == 8'h1d |=> reg_rdata == 24'h0)
    else $error("reserved word not zero");
  rsvd_fixed_a: assert property (reg_read && reg_addr == 8'h20 |=> reg_rdata == 24'h20)
    else $error("fixed word wrong");
  pump_hiz_a: assert property (charge_pump_hiz == detector_reset)
    else $error("pump not floated");
  kick_fire_a: assert property (slip_guard_active && phase_error_full_cycle
    && !detector_reset |=> slip_guard_kick) else $error("kick missing");
  gate_need_a: assert property (slip_guard_active |-> slip_global_en)
    else $error("slip guard ungated");
  lock_update_a: assert property (lock_window_done |=>
    lock_flag == ($past(lock_window_count) >= $past(lock_thresh))) else $error("lock wrong");
  lock_hold_a: assert property (!lock_window_done |=> $stable(lock_flag))
    else $error("lock moved");
  status_bits_a: assert property (reg_read && reg_addr == 8'h1f |=>
    reg_rdata[4] == 1'b0 && reg_rdata[0] == $past(lock_flag)) else $error("status wrong");
  cover property (slip_guard_kick);
  cover property ($rose(lock_flag));
  cover property (reg_read && reg_addr == 8'h1f);
endmodule // ptcs_chk
bind ptcs_regs ptcs_chk i_chk (
  .sys_clk(sys_clk),
  .reset(reset),
  .reg_addr(reg_addr),
  .reg_read(reg_read),
  .reg_rdata(reg_rdata),
  .lock_thresh(lock_thresh),
  .lock_window_count(lock_window_count),
  .lock_window_done(lock_window_done),
  .slip_global_en(slip_global_en),
  .phase_error_full_cycle(phase_error_full_cycle),
  .slip_guard_active(slip_guard_active),
  .slip_guard_kick(slip_guard_kick),
  .detector_reset(detector_reset),
  .charge_pump_hiz(charge_pump_hiz),
  .lock_flag(lock_flag)
);

/* File: tb/test_ptcs_regs.sv */
`timescale 1ns/100ps
module test_ptcs_regs;
  logic sys_clk = 0, reset = 1, reg_write = 0, reg_read = 0, lock_window_done = 0;
  logic slip_global_en = 1, phase_error_full_cycle = 0, sweep_active_flag = 1;
  logic temp_sample_strobe = 0, reg_rvalid, slip_guard_active, slip_guard_kick;
  logic slip_guard_retard, detector_reset, charge_pump_hiz, temp_sensor_enable, lock_flag;
  logic [7:0] reg_addr = 0;
  logic [23:0] reg_wdata = 0, reg_rdata, got;
  logic got_v;
  logic [9:0] lock_thresh = 10'h040, lock_window_count = 0;
  logic [2:0] modulator_overflow_flags = 3'h5, aux_pad_data = 3'h6;
  logic [2:0] aux_output_pin_data, aux_output_pin_oe;
  logic [3:0] slip_guard_step;
  logic signed [9:0] temp_celsius = 0;
  int n_mismatch = 0, tests_run = 0;
  int tc[4] = '{25, 82, 83, -23};
  logic [23:0] te[4] = '{24'h3, 24'h6, 24'h7, 24'h0};
  // address, write flag, write data, expected read
  logic [56:0] rows[9] = '{{8'h1c, 49'h0_000020}, {8'h1d, 49'h1_ffffff_000000},
    {8'h1e, 49'h0_000000}, {8'h20, 49'h1_000000_000020}, {8'h21, 49'h1_000000_00001f},
    {8'h22, 49'h1_000001_000000}, {8'h1f, 49'h1_ffffff_00002a},
    {8'h40, 49'h1_000007_000000}, {8'h1b, 49'h1_000580_000580}};
  ptcs_regs i_dut (
    .sys_clk(sys_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .lock_thresh(lock_thresh),
    .lock_window_count(lock_window_count),
    .lock_window_done(lock_window_done),
    .slip_global_en(slip_global_en),
    .phase_error_full_cycle(phase_error_full_cycle),
    .modulator_overflow_flags(modulator_overflow_flags),
    .sweep_active_flag(sweep_active_flag),
    .temp_sample_strobe(temp_sample_strobe),
    .temp_celsius(temp_celsius),
    .aux_pad_data(aux_pad_data),
    .aux_output_pin_data(aux_output_pin_data),
    .aux_output_pin_oe(aux_output_pin_oe),
    .slip_guard_active(slip_guard_active),
    .slip_guard_kick(slip_guard_kick),
    .slip_guard_retard(slip_guard_retard),
    .slip_guard_step(slip_guard_step),
    .detector_reset(detector_reset),
    .charge_pump_hiz(charge_pump_hiz),
    .temp_sensor_enable(temp_sensor_enable),
    .lock_flag(lock_flag)
  );
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, input logic [23:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= wr;
    reg_read <= !wr;
    @(posedge sys_clk);
    reg_write <= 0;
    reg_read <= 0;
    #1 got = reg_rdata;
    got_v = reg_rvalid;
    @(posedge sys_clk);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      if (rows[i][48]) acc(1, rows[i][56:49], rows[i][47:24]);
      acc(0, rows[i][56:49], 24'h0);
      chk(got, rows[i][23:0]);
      chk({23'h0, got_v}, 24'h1);
    end
    chk({21'h0, aux_output_pin_oe}, 24'h2);
    chk({21'h0, aux_output_pin_data}, 24'h6);
    acc(1, 8'h1b, 24'h000700);
    chk({21'h0, aux_output_pin_oe}, 24'h0);
    $display("register table done");
    acc(1, 8'h1c, 24'h000015);
    chk({22'h0, detector_reset, charge_pump_hiz}, 24'h3);
    acc(1, 8'h1c, 24'h000035);
    phase_error_full_cycle <= 1;
    repeat (2) @(posedge sys_clk);
    #1 chk({22'h0, slip_guard_kick, slip_guard_retard}, 24'h3);
    chk({20'h0, slip_guard_step}, 24'h5);
    @(posedge sys_clk);
    slip_global_en <= 0;
    @(posedge sys_clk);
    #1 chk({23'h0, slip_guard_active}, 24'h0);
    @(posedge sys_clk);
    slip_global_en <= 1;
    acc(1, 8'h1c, 24'h000020);
    chk({23'h0, slip_guard_active}, 24'h0);
    $display("slip guard done");
    for (int k = 0; k < 2; k++) begin
      lock_window_count <= 10'h040 - k;
      lock_window_done <= 1;
      @(posedge sys_clk);
      lock_window_done <= 0;
      acc(0, 8'h1f, 24'h0);
      chk(got, 24'h2b - k);
    end
    sweep_active_flag <= 0;
    modulator_overflow_flags <= 3'h2;
    acc(0, 8'h1f, 24'h0);
    chk(got, 24'h4);
    $display("lock status done");
    acc(1, 8'h1e, 24'h000001);
    chk({23'h0, temp_sensor_enable}, 24'h1);
    foreach (tc[k]) begin
      temp_celsius <= tc[k];
      temp_sample_strobe <= 1;
      @(posedge sys_clk);
      temp_sample_strobe <= 0;
      @(posedge sys_clk);
      acc(0, 8'h21, 24'h0);
      chk(got, te[k]);
    end
    $display("temperature done");
    reset <= 1;
    @(posedge sys_clk);
    reset <= 0;
    @(posedge sys_clk);
    acc(0, 8'h21, 24'h0);
    chk(got, 24'h1f);
    $display("second reset done");
    close_out();
  end
endmodule // test_ptcs_regs
